/* File: rtl/epc_counter.sv */
// Implementation choices: the register addresses and strobed register access.
`timescale 1ns/10ps
module epc_counter
    import epc_pkg::*;
(
    // Clock and reset.
    input  wire logic        mclk,
    input  wire logic        arst_n,
    // Register port.
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr_stb,
    input  wire logic        rd_stb,
    output logic      [31:0] rdata_q,
    // Encoder, trigger and sample clock pins.
    input  wire logic [3:0]  programmable_function_input,
    // Live position.
    output logic      [31:0] position_q
);

    // Picks one of the four conditioned pins.
    function automatic logic pick(input logic [3:0] v, input logic [1:0] s);
        pick = v[s];
    endfunction

    logic [3:0]  meta_q;
    logic [3:0]  sync_q;
    logic [3:0]  filt_q;
    logic [3:0]  prev_q;
    logic [3:0]  fcnt_q [4];
    epc_cfg_t    cfg_q;
    logic [31:0] init_q;
    logic [31:0] reload_q;
    epc_run_t    run_q;
    logic [31:0] mem [FIFO_DEPTH];
    logic [FIFO_AW-1:0] wr_ptr_q;
    logic [FIFO_AW-1:0] rd_ptr_q;
    logic [FIFO_AW:0]   level_q;
    logic        ovf_q;
    logic        a_cur;
    logic        a_old;
    logic        b_cur;
    logic        b_old;
    logic        z_cur;
    logic        a_rise;
    logic        a_fall;
    logic        b_rise;
    logic        a_chg;
    logic        b_chg;
    logic        step_up;
    logic        step_dn;
    logic        phase_hit;
    logic        arm_hit;
    logic        sclk_hit;
    logic        cmd_wr;
    logic        start;
    logic        stop;
    logic        counting;
    logic        full;
    logic        push;
    logic        pop;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);

    // Two-stage synchronizer; only the second stage is read by logic.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            meta_q <= 4'h0;
            sync_q <= 4'h0;
        end else begin
            meta_q <= programmable_function_input;
            sync_q <= meta_q;
        end
    end

    // Noise filter: a pin is taken once stable for the filter time.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            filt_q <= 4'h0;
            for (int i = 0; i < 4; i++) begin
                fcnt_q[i] <= 4'h0;
            end
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (!cfg_q.filt_en) begin
                    filt_q[i] <= sync_q[i];
                    fcnt_q[i] <= 4'h0;
                end else if (sync_q[i] == filt_q[i]) begin
                    fcnt_q[i] <= 4'h0;
                end else if (fcnt_q[i] == FILT_LAST) begin
                    filt_q[i] <= sync_q[i];
                    fcnt_q[i] <= 4'h0;
                end else begin
                    fcnt_q[i] <= fcnt_q[i] + 4'h1;
                end
            end
        end
    end

    // Previous levels for edge detection in the timebase domain.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            prev_q <= 4'h0;
        end else begin
            prev_q <= filt_q;
        end
    end

    // Channel routing and edges.
    assign a_cur  = pick(filt_q, cfg_q.phase_a_input_select);
    assign a_old  = pick(prev_q, cfg_q.phase_a_input_select);
    assign b_cur  = pick(filt_q, cfg_q.phase_b_input_select);
    assign b_old  = pick(prev_q, cfg_q.phase_b_input_select);
    assign z_cur  = pick(filt_q, cfg_q.index_input_select);
    assign a_rise = a_cur & ~a_old;
    assign a_fall = ~a_cur & a_old;
    assign b_rise = b_cur & ~b_old;
    assign a_chg  = a_cur ^ a_old;
    assign b_chg  = b_cur ^ b_old;

    // Step decoder for the selected decoding type.
    always_comb begin
        step_up = 1'b0;
        step_dn = 1'b0;
        unique case (cfg_q.decode)
            DEC_TWO_PULSE: begin
                step_up = a_rise & ~b_rise;
                step_dn = b_rise & ~a_rise;
            end
            DEC_X1: begin
                step_up = a_rise & ~b_cur;
                step_dn = a_fall & ~b_cur;
            end
            DEC_X2: begin
                if (a_chg && !b_chg) begin
                    step_up = a_cur ^ b_cur;
                    step_dn = ~(a_cur ^ b_cur);
                end
            end
            DEC_X4: begin
                if (a_chg && !b_chg) begin
                    step_up = a_cur ^ b_cur;
                    step_dn = ~(a_cur ^ b_cur);
                end else if (b_chg && !a_chg) begin
                    step_up = ~(a_cur ^ b_cur);
                    step_dn = a_cur ^ b_cur;
                end
            end
        endcase
    end

    // Reload phase: Z high while {B, A} equals the configured pair.
    assign phase_hit = cfg_q.z_enable & z_cur
                     & ({b_cur, a_cur} == cfg_q.z_phase);

    // Arm trigger and sample clock edges.
    always_comb begin
        arm_hit = 1'b0;
        sclk_hit = 1'b0;
        if (cfg_q.arm_trigger_polarity) begin
            arm_hit = pick(filt_q, cfg_q.arm_trigger_source)
                    & ~pick(prev_q, cfg_q.arm_trigger_source);
        end else begin
            arm_hit = ~pick(filt_q, cfg_q.arm_trigger_source)
                    & pick(prev_q, cfg_q.arm_trigger_source);
        end
        if (cfg_q.sclk_rise) begin
            sclk_hit = pick(filt_q, cfg_q.sclk_src) & ~pick(prev_q, cfg_q.sclk_src);
        end else begin
            sclk_hit = ~pick(filt_q, cfg_q.sclk_src) & pick(prev_q, cfg_q.sclk_src);
        end
    end

    // Commands.
    assign cmd_wr   = wr_stb & (addr == OFS_CMD);
    assign start    = cmd_wr & wdata[CMD_START];
    assign stop     = cmd_wr & wdata[CMD_STOP];
    assign counting = (run_q == RUN_COUNT);

    // Configuration registers.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            cfg_q    <= CFG_RESET;
            init_q   <= INIT_RESET;
            reload_q <= RELOAD_RESET;
        end else if (wr_stb) begin
            if (addr == OFS_CTRL) begin
                cfg_q <= epc_cfg_t'(wdata[19:0]);
            end
            if (addr == OFS_INIT) begin
                init_q <= wdata;
            end
            if (addr == OFS_RELOAD) begin
                reload_q <= wdata;
            end
        end
    end

    // Run control: start arms or counts at once; stop returns to idle.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            run_q <= RUN_IDLE;
        end else if (stop) begin
            run_q <= RUN_IDLE;
        end else if (start) begin
            run_q <= cfg_q.arm_trigger_kind ? RUN_ARMWAIT : RUN_COUNT;
        end else if (run_q == RUN_ARMWAIT && arm_hit) begin
            run_q <= RUN_COUNT;
        end
    end

    // Position counter; a step wins over a reload in the same cycle.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            position_q <= 32'h0000_0000;
        end else if (start) begin
            position_q <= init_q;
        end else if (counting && !stop) begin
            if (step_up) begin
                position_q <= position_q + 32'h0000_0001;
            end else if (step_dn) begin
                position_q <= position_q - 32'h0000_0001;
            end else if (phase_hit) begin
                position_q <= reload_q;
            end
        end
    end

    // Sample buffer control.
    assign full = (level_q == (FIFO_AW + 1)'(FIFO_DEPTH));
    assign push = counting & cfg_q.sclk_mode & sclk_hit & ~full & ~start;
    assign pop  = rd_stb & (addr == OFS_FIFO) & (level_q != '0);

    // Buffer storage.
    always_ff @(posedge mclk) begin
        if (push) begin
            mem[wr_ptr_q] <= position_q;
        end
    end

    // Buffer pointers; start flushes old samples.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            level_q  <= '0;
        end else if (start) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            level_q  <= '0;
        end else begin
            if (push) begin
                wr_ptr_q <= wr_ptr_q + 1'b1;
            end
            if (pop) begin
                rd_ptr_q <= rd_ptr_q + 1'b1;
            end
            if (push && !pop) begin
                level_q <= level_q + 1'b1;
            end else if (pop && !push) begin
                level_q <= level_q - 1'b1;
            end
        end
    end

    // Overflow flag: a lost sample sets it; setting wins over clearing.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            ovf_q <= 1'b0;
        end else if (counting && cfg_q.sclk_mode && sclk_hit && full) begin
            ovf_q <= 1'b1;
        end else if (wr_stb && addr == OFS_STATUS && wdata[STS_CLR_OV]) begin
            ovf_q <= 1'b0;
        end
    end

    // Read data stand for one cycle after the read strobe only.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_q <= 32'h0000_0000;
        end else begin
            rdata_q <= 32'h0000_0000;
            if (rd_stb) begin
                case (addr)
                    OFS_CTRL:   rdata_q <= {12'h000, cfg_q};
                    OFS_INIT:   rdata_q <= init_q;
                    OFS_RELOAD: rdata_q <= reload_q;
                    OFS_COUNT:  rdata_q <= position_q;
                    OFS_STATUS: rdata_q <= {24'h000000, level_q, ovf_q,
                                            run_q == RUN_ARMWAIT, counting};
                    OFS_FIFO:   rdata_q <= pop ? mem[rd_ptr_q] : 32'h0000_0000;
                    default:    rdata_q <= 32'h0000_0000;
                endcase
            end
        end
    end

    // X1 down count on a falling A with B low.
    AST_X1_DOWN: assert property (
        counting && !cmd_wr && cfg_q.decode == DEC_X1 && a_fall && !b_cur
        |=> position_q == $past(position_q) - 32'h0000_0001)
        else $error("X1 falling A did not count down");

    // X4 counts up on B rising while A is high.
    AST_X4_UP_B: assert property (
        counting && !cmd_wr && cfg_q.decode == DEC_X4 && b_rise && a_cur && !a_chg
        |=> position_q == $past(position_q) + 32'h0000_0001)
        else $error("X4 B edge did not count up");

    // X2 ignores B edges.
    AST_X2_B_QUIET: assert property (
        counting && !cmd_wr && cfg_q.decode == DEC_X2 && b_chg && !a_chg
        && !phase_hit |=> $stable(position_q))
        else $error("X2 counted on a B edge");

    // Two-pulse counts down on B rising alone.
    AST_TWO_PULSE_DN: assert property (
        counting && !cmd_wr && cfg_q.decode == DEC_TWO_PULSE && b_rise && !a_rise
        |=> position_q == $past(position_q) - 32'h0000_0001)
        else $error("Two-pulse B rise did not count down");

    // Reload is done by the next edge when no step is due.
    AST_RELOAD: assert property (
        counting && !cmd_wr && phase_hit && !step_up && !step_dn
        |=> position_q == $past(reload_q))
        else $error("Index reload missing");

    // Step first, then reload on the following cycle if the phase holds.
    AST_STEP_FIRST: assert property (
        counting && !cmd_wr && phase_hit && step_up
        |=> position_q == $past(position_q) + 32'h0000_0001)
        else $error("Reload overtook a step");

    // While waiting for the arm trigger the count stands still.
    AST_ARM_HOLD: assert property (
        run_q == RUN_ARMWAIT && !cmd_wr |=> $stable(position_q))
        else $error("Counted before arm trigger");

    // Start loads the initial position.
    AST_START_LOAD: assert property (
        start && !stop |=> position_q == $past(init_q) ##1 run_q != RUN_IDLE)
        else $error("Start did not load initial position");

    // Count readback returns the present count.
    AST_READ_COUNT: assert property (
        rd_stb && addr == OFS_COUNT |=> rdata_q == $past(position_q))
        else $error("Count read returned a stale value");

    // A sample edge stores the present count.
    AST_SAMPLE: assert property (
        push |=> mem[$past(wr_ptr_q)] == $past(position_q)
                 && level_q != '0)
        else $error("Sample not captured");

endmodule // epc_counter

/* File: rtl/epc_pkg.sv */
package epc_pkg;

    // Counter timebase.
    localparam int CLK_MHZ       = 100;
    localparam int CLK_PERIOD_NS = 1000 / CLK_MHZ;

    // Optional noise filter: least stable time of a pin before it is taken.
    localparam int FILT_TIME_NS = 100;
    localparam int FILT_CYCLES  = (FILT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] FILT_LAST = 4'(FILT_CYCLES - 1);

    // Sample buffer.
    localparam int FIFO_DEPTH = 16;
    localparam int FIFO_AW    = 4;

    // Register byte offsets.
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_INIT   = 8'h04;
    localparam logic [7:0] OFS_RELOAD = 8'h08;
    localparam logic [7:0] OFS_COUNT  = 8'h0C;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam logic [7:0] OFS_FIFO   = 8'h14;
    localparam logic [7:0] OFS_CMD    = 8'h18;

    // Command and status bit positions.
    localparam int CMD_START  = 0;
    localparam int CMD_STOP   = 1;
    localparam int STS_CLR_OV = 2;

    // Values after reset.
    localparam logic [31:0] INIT_RESET   = 32'h0000_0000;
    localparam logic [31:0] RELOAD_RESET = 32'h0000_0000;

    // Decoding types.
    typedef enum logic [1:0] {
        DEC_TWO_PULSE,
        DEC_X1,
        DEC_X2,
        DEC_X4
    } epc_decode_t;

    // Run states.
    typedef enum logic [1:0] {
        RUN_IDLE,
        RUN_ARMWAIT,
        RUN_COUNT
    } epc_run_t;

    // Configuration word, bit 0 upward: filter, decode, index, selects, arm, sample.
    typedef struct packed {
        logic [1:0]  sclk_src;
        logic        sclk_rise;
        logic        sclk_mode;
        logic [1:0]  arm_trigger_source;
        logic        arm_trigger_polarity;
        logic        arm_trigger_kind;
        logic [1:0]  index_input_select;
        logic [1:0]  phase_b_input_select;
        logic [1:0]  phase_a_input_select;
        logic [1:0]  z_phase;
        logic        z_enable;
        epc_decode_t decode;
        logic        filt_en;
    } epc_cfg_t;

    localparam epc_cfg_t CFG_RESET = 20'h00000;

endpackage

/* File: tb/epc_enc_model.sv */
`timescale 1ns/10ps
// Encoder on the far side of the pins: channel A on bit 0, B on bit 1, Z on bit 2.
module epc_enc_model (
    // Timebase clock.
    input  wire logic       mclk,
    // Encoder channels.
    output logic      [2:0] enc_q
);
    // Cycles each level stands, longer than the unfiltered pin-to-count delay of the block.
    localparam int HOLD = 6;
    int            ph;

    // Channels rest low with the index off.
    initial begin
        enc_q = 3'h0;
        ph = 0;
    end

    // Walks the Gray cycle; +1 lets A lead B, -1 lets B lead A.
    task automatic step(input int dir, input int n);
        repeat (n) begin
            @(posedge mclk);
            ph = ph + dir;
            enc_q[1:0] <= 2'(ph) ^ (2'(ph) >> 1);
            repeat (HOLD) @(posedge mclk);
        end
    endtask

    // Index level; the caller keeps it high across part of the chosen phase.
    task automatic zset(input logic v);
        @(posedge mclk);
        enc_q[2] <= v;
        repeat (HOLD) @(posedge mclk);
    endtask

    // One whole pulse on channel A or B, as a two-pulse encoder sends it.
    task automatic pulse(input int ch);
        @(posedge mclk);
        enc_q[ch] <= 1'b1;
        repeat (HOLD) @(posedge mclk);
        enc_q[ch] <= 1'b0;
        repeat (HOLD) @(posedge mclk);
    endtask
endmodule // epc_enc_model

/* File: tb/testbench.sv */
`timescale 1ns/10ps
module testbench;
    import epc_pkg::*;
    // Clock, reset and register port.
    logic        mclk;
    logic        arst_n;
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr_stb;
    logic        rd_stb;
    logic [31:0] rdata_q;
    // Pins and live count.
    logic [2:0]  enc;
    logic        trig;
    logic [31:0] position_q;
    int          bad_count;
    int          compares;

    // Timebase at 100 MHz.
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // Pin 3 carries both the arm trigger and the sample clock.
    epc_counter i_dut (
        .mclk                        (mclk),
        .arst_n                      (arst_n),
        .addr                        (addr),
        .wdata                       (wdata),
        .wr_stb                      (wr_stb),
        .rd_stb                      (rd_stb),
        .rdata_q                     (rdata_q),
        .programmable_function_input ({trig, enc}),
        .position_q                  (position_q)
    );

    epc_enc_model i_enc (
        .mclk  (mclk),
        .enc_q (enc)
    );

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge mclk);
        wr_stb <= 1'b0;
        #1;
    endtask

    // Read data stand only in the cycle after the strobe.
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string name);
        @(posedge mclk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge mclk);
        rd_stb <= 1'b0;
        #1;
        check(name, rdata_q, exp);
    endtask

    // Encoder on pins 0..2, trigger and sample clock on pin 3.
    function automatic epc_cfg_t mk(input epc_decode_t d);
        epc_cfg_t c;
        c = CFG_RESET;
        c.decode = d;
        c.phase_b_input_select = 2'h1;
        c.index_input_select = 2'h2;
        c.arm_trigger_source = 2'h3;
        c.sclk_src = 2'h3;
        return c;
    endfunction

    task automatic run(input epc_cfg_t c, input logic [31:0] init);
        wr(OFS_CTRL, 32'(c));
        wr(OFS_INIT, init);
        wr(OFS_CMD, 32'h1);
    endtask

    task automatic tpulse;
        @(posedge mclk);
        trig <= 1'b1;
        repeat (6) @(posedge mclk);
        trig <= 1'b0;
        repeat (6) @(posedge mclk);
    endtask

    // Values after reset, refusals, and no counting before start.
    task automatic t_reset;
        rd_chk(OFS_CTRL, 32'(CFG_RESET), "ctrl");
        rd_chk(OFS_INIT, INIT_RESET, "init");
        rd_chk(OFS_RELOAD, RELOAD_RESET, "reload");
        i_enc.step(1, 4);
        check("idle_pos", position_q, 32'h0);
        wr(OFS_COUNT, 32'h55);
        rd_chk(OFS_COUNT, 32'h0, "count_ro");
        rd_chk(8'h20, 32'h0, "unmapped");
    endtask

    // One cycle forward and back in each quadrature mode.
    task automatic t_quad;
        int per [3] = '{1, 2, 4};
        for (int i = 0; i < 3; i++) begin
            run(mk(epc_decode_t'(i + 1)), 32'h64);
            check("start_pos", position_q, 32'h64);
            i_enc.step(1, 4);
            rd_chk(OFS_COUNT, 32'h64 + 32'(per[i]), "count_up");
            i_enc.step(-1, 4);
            check("count_down", position_q, 32'h64);
        end
    endtask

    task automatic t_two;
        run(mk(DEC_TWO_PULSE), 32'h32);
        repeat (3) i_enc.pulse(0);
        i_enc.pulse(1);
        check("two_pulse", position_q, 32'h34);
        // Stop returns to idle, so a later pulse leaves the count alone.
        wr(OFS_CMD, 32'h2);
        rd_chk(OFS_STATUS, 32'h0, "stopped");
        i_enc.pulse(0);
        check("stop_hold", position_q, 32'h34);
    endtask

    // With the filter on, six-cycle pulses are dropped and a long one counts.
    task automatic t_filter;
        epc_cfg_t c;
        c = mk(DEC_TWO_PULSE);
        c.filt_en = 1'b1;
        c.phase_a_input_select = 2'h3;
        run(c, 32'h14);
        tpulse();
        i_enc.pulse(1);
        check("short_pulse", position_q, 32'h14);
        @(posedge mclk);
        trig <= 1'b1;
        repeat (12) @(posedge mclk);
        trig <= 1'b0;
        repeat (14) @(posedge mclk);
        check("long_pulse", position_q, 32'h15);
    endtask

    // Z rises out of phase, then the step into phase {B,A}=11 counts before the reload.
    task automatic t_index(input logic zen);
        epc_cfg_t c;
        c = mk(DEC_X4);
        c.z_enable = zen;
        c.z_phase = 2'h3;
        wr(OFS_RELOAD, 32'h1F4);
        run(c, 32'h64);
        i_enc.step(1, 1);
        i_enc.zset(1'b1);
        check("off_phase", position_q, 32'h65);
        i_enc.step(1, 1);
        check("reload", position_q, zen ? 32'h1F4 : 32'h66);
        i_enc.zset(1'b0);
        i_enc.step(1, 2);
        check("after_reload", position_q, zen ? 32'h1F6 : 32'h68);
    endtask

    task automatic t_arm;
        epc_cfg_t c;
        c = mk(DEC_X4);
        c.arm_trigger_kind = 1'b1;
        c.arm_trigger_polarity = 1'b1;
        run(c, 32'hC8);
        rd_chk(OFS_STATUS, 32'h2, "arm_wait");
        i_enc.step(1, 2);
        check("held_off", position_q, 32'hC8);
        i_enc.step(-1, 2);
        tpulse();
        rd_chk(OFS_STATUS, 32'h1, "armed");
        i_enc.step(1, 4);
        check("arm_count", position_q, 32'hCC);
    endtask

    // Two samples read back in order, then the buffer is overfilled.
    task automatic t_sample;
        epc_cfg_t c;
        c = mk(DEC_X4);
        c.sclk_mode = 1'b1;
        c.sclk_rise = 1'b1;
        run(c, 32'hA);
        i_enc.step(1, 1);
        tpulse();
        i_enc.step(1, 1);
        tpulse();
        rd_chk(OFS_STATUS, 32'h11, "fifo_lvl");
        rd_chk(OFS_FIFO, 32'hB, "sample1");
        rd_chk(OFS_FIFO, 32'hC, "sample2");
        rd_chk(OFS_FIFO, 32'h0, "empty_pop");
        repeat (FIFO_DEPTH + 1) tpulse();
        rd_chk(OFS_STATUS, 32'h85, "overflow");
        wr(OFS_STATUS, 32'h4);
        rd_chk(OFS_STATUS, 32'h81, "ov_clear");
        i_enc.step(-1, 2);
    endtask

    task automatic print_verdict;
        $display("compares=%0d bad_count=%0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Main sequence.
    initial begin
        arst_n = 1'b0;
        addr = 8'h00;
        wdata = 32'h0;
        wr_stb = 1'b0;
        rd_stb = 1'b0;
        trig = 1'b0;
        bad_count = 0;
        compares = 0;
        repeat (6) @(posedge mclk);
        arst_n <= 1'b1;
        t_reset();
        t_quad();
        t_two();
        t_filter();
        t_index(1'b1);
        t_index(1'b0);
        t_arm();
        t_sample();
        print_verdict();
    end

    // The tests need under a thousand cycles; this cuts a hang short.
    initial begin
        repeat (20000) @(posedge mclk);
        bad_count++;
        print_verdict();
    end
endmodule // testbench
